// ===== shared/scl_pkg.sv
package scl_pkg;

    // ****************************************************************
    // Timing constants
    // ****************************************************************

    // Clock period of pclk in nanoseconds (125 MHz).
    localparam int CLK_NS = 8;
    // Least visible on-time of a stretched indicator event, in milliseconds.
    localparam int STRETCH_MS = 50;
    localparam int STRETCH_CYC = STRETCH_MS * 1_000_000 / CLK_NS;
    // Run blinker half period at zero load, in milliseconds.
    localparam int RUN_BASE_MS = 250;
    localparam int RUN_BASE_CYC = RUN_BASE_MS * 1_000_000 / CLK_NS;
    // Extra half period per unit of processor load, in microseconds.
    localparam int RUN_STEP_US = 1000;
    localparam int RUN_STEP_CYC = RUN_STEP_US * 1000 / CLK_NS;
    // Fill count at which the switch synchroniser output is settled.
    localparam logic [1:0] FILL_LAST = 2'h2;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************

    localparam logic [11:0] ADDR_LEDSEL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_PEAK   = 12'h008;
    localparam logic [11:0] ADDR_ACT    = 12'h00C;
    // Default indicator mapping: indicator i shows function i.
    localparam logic [17:0] LEDSEL_RST  = 18'h2_C688;
    // Default level thresholds on the linear magnitude scale.
    localparam logic [15:0] PEAK_THR_RST = 16'h7000;
    localparam logic [15:0] ACT_THR_RST  = 16'h0200;

    // ****************************************************************
    // Switch bank positions (1 = switch ON)
    // ****************************************************************

    localparam int SW_PCM_M  = 0;
    localparam int SW_NIB_M  = 1;
    localparam int SW_ADAPT  = 2;
    localparam int SW_TRUNC  = 3;
    localparam int SW_LINSRC = 4;
    localparam int SW_MODE_A = 6;
    localparam int SW_MODE_B = 7;
    localparam int N_LED     = 6;
    localparam int N_STR     = 3;

    // Operating modes, coded as {seventh switch, eighth switch}.
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_LEGACY = 2'h1,
        MODE_STANDALONE = 2'h2,
        MODE_TEST = 2'h3
    } scl_mode_t;

    // Indicator function codes used by the reassignment selector.
    typedef enum logic [2:0] {
        FN_AUDIO_PEAK = 3'h0,
        FN_AUDIO_ACT = 3'h1,
        FN_TRUNC = 3'h2,
        FN_ERROR = 3'h3,
        FN_VOCODER_ACT = 3'h4,
        FN_RUN = 3'h5,
        FN_OFF = 3'h6,
        FN_ON = 3'h7
    } scl_fn_t;

    // Loader states.
    typedef enum logic {ST_FILL, ST_RUN} scl_state_t;

endpackage : scl_pkg

// ===== verilog/scl_sync.sv
`timescale 1ns/1ns

// Two-stage synchroniser for a bank of quasi-static inputs.
module scl_sync #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Raw and settled data.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // A bank needs at least one line.
    if (W < 1) begin : g_chk
        $error("scl_sync: W must be at least one");
    end

    // ****************************************************************
    // State
    // ****************************************************************

    // The first stage is read by the second stage and nothing else.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } scl_sync_t;

    scl_sync_t r;   // Registered state.
    scl_sync_t n;   // Next state.

    // Shift the input through both stages.
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    // Register the state; reset clears both stages.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;

endmodule : scl_sync

// ===== verilog/scl_stretch.sv
`timescale 1ns/1ns

// Pulse stretcher: a single-cycle event holds the output high for MIN cycles.
module scl_stretch #(
    parameter int MIN = 16
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Event in, stretched level out.
    input  wire logic ev,
    output logic      on
);

    // A zero on-time would never light the indicator.
    if (MIN < 1) begin : g_chk
        $error("scl_stretch: MIN must be at least one");
    end

    // ****************************************************************
    // State
    // ****************************************************************

    typedef struct packed {
        logic [31:0] cnt;   // Remaining on-time.
        logic        on;    // Stretched output.
    } scl_str_t;

    scl_str_t r;    // Registered state.
    scl_str_t n;    // Next state.

    // A fresh event restarts the full on-time, so repeated events keep it lit.
    always_comb begin
        n = r;
        if (ev) begin
            n.cnt = 32'(MIN);
            n.on  = 1'b1;
        end else if (r.cnt > 32'h0000_0001) begin
            n.cnt = r.cnt - 32'h0000_0001;
            n.on  = 1'b1;
        end else begin
            n.cnt = 32'h0000_0000;
            n.on  = 1'b0;
        end
    end

    // Register the state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign on = r.on;

endmodule : scl_stretch

// ===== verilog/scl_top.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// - Switches captured once after reset, then frozen.
// - Sample-port timing master follows first switch.
// - Nibble timing master follows second switch.
// - Rate adapter only with switch and truncated timing.
// - Test mode ignores adapter and truncated switches.
// - Truncated switch selects truncated or normal timing.
// - Legacy mode: switch picks sample port or codec.
// - Linear-source switch ignored outside legacy mode.
// - Seventh and eighth switches decode four modes.
// - Peak indicator lights at peak threshold.
// - Activity indicator lights at activity threshold.
// - Truncated indicator lit while truncated timing active.
// - Error indicator lights per error or slip.
// - Vocoder indicator on running encoder or decoder voice.
// - Run indicator blinks, rate follows processor load.
// - Each indicator output reassignable to any function.
module scl_top
    import scl_pkg::*;
#(
    parameter int STRETCH_CYCLES  = scl_pkg::STRETCH_CYC,
    parameter int RUN_BASE_CYCLES = scl_pkg::RUN_BASE_CYC,
    parameter int RUN_STEP_CYCLES = scl_pkg::RUN_STEP_CYC
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Configuration switch bank.
    input  wire logic [7:0]  switch_in,
    // Status sources from the vocoder logic.
    input  wire logic [15:0] audio_level,
    input  wire logic        sample_slip,
    input  wire logic        error_event,
    input  wire logic        enc_running,
    input  wire logic        enc_voice,
    input  wire logic        dec_running,
    input  wire logic        dec_voice,
    input  wire logic [7:0]  cpu_load,
    // Decoded configuration.
    output logic             pcm_timing_master,
    output logic             nibble_timing_master,
    output logic             rate_adapter_enable,
    output logic             truncated_timing_enable,
    output logic             linear_source_pcm,
    output logic      [1:0]  operating_mode_select,
    // Indicator outputs, active high.
    output logic      [5:0]  status_led
);
    import scl_pkg::*;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************

    // The stretch must cover the eight-cycle check below; counters must reload.
    if (STRETCH_CYCLES < 8 || RUN_BASE_CYCLES < 1 || RUN_STEP_CYCLES < 0) begin : g_chk
        $error("scl_top: unsupported timing parameter");
    end

    // ****************************************************************
    // State
    // ****************************************************************

    typedef struct packed {
        scl_state_t  st;        // Loader state.
        logic [1:0]  fill;      // Synchroniser fill count.
        logic [7:0]  sw;        // Captured switch image.
        logic [1:0]  mode;      // Decoded operating mode.
        logic        trunc;     // Truncated timing active.
        logic        adapt;     // Rate adapter enabled.
        logic        pcmm;      // Sample-port timing master.
        logic        nibm;      // Nibble timing master.
        logic        linsrc;    // Sample port feeds the vocoder.
        logic [17:0] ledsel;    // Function select, three bits per indicator.
        logic [15:0] peak_thr;  // Peak threshold.
        logic [15:0] act_thr;   // Activity threshold.
        logic [31:0] blink;     // Run blinker countdown.
        logic        run;       // Run blinker phase.
        logic [5:0]  led;       // Indicator outputs.
        logic [31:0] prdata;    // Read data.
        logic        pready;    // Access-phase ready.
        logic        pslverr;   // Unmapped address.
    } scl_top_t;

    scl_top_t   r;          // Registered state.
    scl_top_t   n;          // Next state.
    logic [7:0] sw_sync;    // Settled switch bank.
    logic [2:0] ev_w;       // Events to stretch: error, activity, peak.
    logic [2:0] str_on;     // Stretched events.
    logic       voice_w;    // Voice at a running coder.
    logic [7:0] fn_w;       // All indicator functions by code.
    logic       fn0_w;      // Function currently routed to indicator 0.

    // ****************************************************************
    // Switch synchroniser and event stretchers
    // ****************************************************************

    // Switches are static, so a plain two-stage synchroniser is enough.
    scl_sync #(.W(8)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (switch_in),
        .q       (sw_sync)
    );

    // Level comparisons and slip events are too brief to see unstretched.
    assign ev_w[0] = audio_level >= r.peak_thr;
    assign ev_w[1] = audio_level >= r.act_thr;
    assign ev_w[2] = sample_slip || error_event;

    for (genvar g = 0; g < N_STR; g++) begin : g_str
        scl_stretch #(.MIN(STRETCH_CYCLES)) u_str (
            .pclk    (pclk),
            .presetn (presetn),
            .ev      (ev_w[g]),
            .on      (str_on[g])
        );
    end

    assign voice_w = (enc_running && enc_voice) || (dec_running && dec_voice);

    // Function table indexed by the function code.
    assign fn_w = {1'b1, 1'b0, r.run, voice_w, str_on[2], r.trunc, str_on[1], str_on[0]};
    assign fn0_w = fn_w[r.ledsel[2:0]];

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Loader, blinker, indicator routing and the APB slave in one place.
    always_comb begin
        n = r;
        // Loader: wait for the synchroniser, capture once, then hold forever.
        case (r.st)
            ST_FILL: begin
                n.fill = r.fill + 2'h1;
                if (r.fill == FILL_LAST) begin
                    n.st     = ST_RUN;
                    n.sw     = sw_sync;
                    n.mode   = {sw_sync[SW_MODE_A], sw_sync[SW_MODE_B]};
                    n.pcmm   = sw_sync[SW_PCM_M];
                    n.nibm   = sw_sync[SW_NIB_M];
                    // Test mode forces normal timing and no adapter.
                    n.trunc  = sw_sync[SW_TRUNC] && (n.mode != MODE_TEST);
                    n.adapt  = sw_sync[SW_ADAPT] && n.trunc;
                    // Only legacy mode looks at the linear-source switch.
                    n.linsrc = sw_sync[SW_LINSRC] && (n.mode == MODE_LEGACY);
                end
            end
            ST_RUN: begin
                n.st = ST_RUN;
            end
            default: begin
                n.st = ST_FILL;
            end
        endcase
        // Run blinker: heavier load gives a longer half period.
        if (r.blink == 32'h0000_0000) begin
            n.blink = 32'(RUN_BASE_CYCLES) + 32'(cpu_load) * 32'(RUN_STEP_CYCLES);
            n.run   = !r.run;
        end else begin
            n.blink = r.blink - 32'h0000_0001;
        end
        // Indicator routing through the function selector.
        for (int i = 0; i < N_LED; i++) begin
            n.led[i] = fn_w[r.ledsel[3*i +: 3]];
        end
        // APB: ready is raised for exactly the first access cycle.
        n.pready = psel && !penable;
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            case (paddr)
                ADDR_LEDSEL: n.prdata = 32'(r.ledsel);
                ADDR_STATUS: n.prdata = {10'h000, r.led, r.st == ST_RUN, r.linsrc,
                                         r.nibm, r.pcmm, r.adapt, r.trunc, r.mode, r.sw};
                ADDR_PEAK:   n.prdata = 32'(r.peak_thr);
                ADDR_ACT:    n.prdata = 32'(r.act_thr);
                default: begin
                    n.prdata  = 32'h0000_0000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        // Writes take effect only at the completing edge; status is read-only.
        if (psel && penable && r.pready && pwrite) begin
            case (paddr)
                ADDR_LEDSEL: n.ledsel   = pwdata[17:0];
                ADDR_PEAK:   n.peak_thr = pwdata[15:0];
                ADDR_ACT:    n.act_thr  = pwdata[15:0];
                default:     n.ledsel   = r.ledsel;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset loads constants only; the switch image is caught after release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.st       <= ST_FILL;
            r.mode     <= MODE_NORMAL;
            r.ledsel   <= LEDSEL_RST;
            r.peak_thr <= PEAK_THR_RST;
            r.act_thr  <= ACT_THR_RST;
        end else begin
            r <= n;
        end
    end

    assign prdata                  = r.prdata;
    assign pready                  = r.pready;
    assign pslverr                 = r.pslverr;
    assign pcm_timing_master       = r.pcmm;
    assign nibble_timing_master    = r.nibm;
    assign rate_adapter_enable     = r.adapt;
    assign truncated_timing_enable = r.trunc;
    assign linear_source_pcm       = r.linsrc;
    assign operating_mode_select   = r.mode;
    assign status_led              = r.led;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Loader leaves the fill state and enters run.
    sequence s_capture;
        r.st == ST_FILL ##1 r.st == ST_RUN;
    endsequence

    AST_CAPTURE: assert property (s_capture |-> r.sw == $past(sw_sync))
        else $error("captured switches differ from synchroniser");
    AST_HOLD: assert property (r.st == ST_RUN |=> r.st == ST_RUN && $stable(r.sw))
        else $error("captured switches changed after capture");
    AST_MASTERS: assert property (r.st == ST_RUN |->
        r.pcmm == r.sw[SW_PCM_M] && r.nibm == r.sw[SW_NIB_M])
        else $error("timing master outputs disagree with switches");
    AST_MODE: assert property (r.st == ST_RUN |->
        r.mode == {r.sw[SW_MODE_A], r.sw[SW_MODE_B]})
        else $error("operating mode decode wrong");
    AST_TRUNC: assert property (r.st == ST_RUN |->
        r.trunc == (r.sw[SW_TRUNC] && r.mode != MODE_TEST))
        else $error("truncated timing decode wrong");
    AST_ADAPT: assert property (r.st == ST_RUN |->
        r.adapt == (r.sw[SW_ADAPT] && r.sw[SW_TRUNC] && r.mode != MODE_TEST))
        else $error("rate adapter enable decode wrong");
    AST_LINSRC: assert property (r.st == ST_RUN && r.mode != MODE_LEGACY |-> !r.linsrc)
        else $error("linear source used outside legacy mode");
    AST_PEAK: assert property (audio_level >= r.peak_thr |=> str_on[0])
        else $error("peak event not shown");
    AST_ERR_MIN: assert property (ev_w[2] |=> str_on[2][*8])
        else $error("error indicator not held");
    AST_VOICE: assert property (voice_w && r.ledsel[14:12] == FN_VOCODER_ACT
        && $stable(r.ledsel) |=> r.led[4])
        else $error("vocoder activity not shown");
    AST_RUN: assert property ($changed(r.run) |-> $past(r.blink) == 32'h0000_0000)
        else $error("run indicator toggled early");
    AST_ROUTE: assert property (1'b1 |=> r.led[0] == $past(fn0_w))
        else $error("indicator 0 not routed to selected function");

    // ****************************************************************
    // Legacy decode, indicator and selector checks
    // ****************************************************************

    // Legacy mode passes the linear-source switch straight through.
    AST_LEGACY: assert property (r.st == ST_RUN && r.mode == MODE_LEGACY |->
        r.linsrc == r.sw[SW_LINSRC])
        else $error("linear source ignores its switch in legacy mode");
    // Activity threshold crossings reach the activity stretcher.
    AST_ACT: assert property (audio_level >= r.act_thr |=> str_on[1])
        else $error("activity event not shown");
    // The truncated indicator tracks the timing mode one cycle later.
    AST_TRUNC_LED: assert property (r.ledsel[8:6] == FN_TRUNC |=>
        r.led[2] == $past(r.trunc))
        else $error("truncated indicator disagrees with timing mode");

    // An error seen while indicator 3 keeps the error function for two cycles.
    sequence s_error_seen;
        ev_w[2] && r.ledsel[11:9] == FN_ERROR ##1 r.ledsel[11:9] == FN_ERROR;
    endsequence

    // The stretcher needs one edge and the indicator register one more.
    AST_ERR_LED: assert property (s_error_seen |=> r.led[3])
        else $error("error indicator not lit after an error");
    // A completed write to the selector lands in full at its completing edge.
    AST_LEDSEL_WR: assert property (psel && penable && r.pready && pwrite
        && paddr == ADDR_LEDSEL |=> 32'(r.ledsel) == ($past(pwdata) & 32'h0003_FFFF))
        else $error("indicator selector write lost");

endmodule : scl_top

// ===== verif/scl_board.sv
`timescale 1ns/1ns

// ****************************************************************
// Board model: switch bank and indicator panel
// ****************************************************************

// Stands for the switch bank and counts changes of the run lamp.
module scl_board (
    // Switch positions chosen by the bench.
    input  wire logic [7:0] sw_set,
    // Indicator lamps driven by the block.
    input  wire logic [5:0] status_led,
    // Switch bank towards the block.
    output logic      [7:0] switch_in,
    // Count of run lamp changes seen so far.
    output int              blinks
);
    // The reserved switch always sits in the off position.
    assign switch_in = sw_set & 8'hDF;

    // Each change of the run lamp is one visible blink step; one process owns the count.
    initial begin
        blinks = 0;
        forever begin
            @(status_led[5]);
            blinks <= blinks + 1;
        end
    end
endmodule : scl_board

// ===== verif/strap_config_and_status_leds_tb_top.sv
`timescale 1ns/1ns

module strap_config_and_status_leds_tb_top;
    import scl_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************

    // Short counts keep the run brief; expectations use them too.
    localparam int STR = 16;
    localparam int RB  = 20;
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  sw_set      = 8'h00;
    logic [7:0]  switch_in;
    logic [15:0] audio_level = 16'h0000;
    logic        sample_slip = 1'b0;
    logic        error_event = 1'b0;
    logic [3:0]  voc         = 4'h0;    // Encoder run, voice, decoder run, voice.
    logic [7:0]  cpu_load    = 8'h00;
    logic [6:0]  cfg;                   // Decoded configuration outputs.
    logic [5:0]  status_led;
    int          blinks;
    int          fails       = 0;
    int          checked     = 0;
    int          n;
    logic [15:0] lfsr        = 16'h0008;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  s;
    logic [6:0]  e;
    logic [15:0] lv[4] = '{16'h01FF, 16'h0200, 16'h6FFF, 16'h7000};
    logic [1:0]  le[4] = '{2'b00, 2'b10, 2'b10, 2'b11};

    // The clock runs at 125 MHz.
    always #4 pclk = ~pclk;

    scl_top #(.STRETCH_CYCLES(STR), .RUN_BASE_CYCLES(RB), .RUN_STEP_CYCLES(1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .switch_in(switch_in),
        .audio_level(audio_level), .sample_slip(sample_slip), .error_event(error_event),
        .enc_running(voc[3]), .enc_voice(voc[2]), .dec_running(voc[1]), .dec_voice(voc[0]),
        .cpu_load(cpu_load), .pcm_timing_master(cfg[0]), .nibble_timing_master(cfg[1]),
        .truncated_timing_enable(cfg[2]), .rate_adapter_enable(cfg[3]),
        .linear_source_pcm(cfg[4]), .operating_mode_select(cfg[6:5]),
        .status_led(status_led));

    scl_board board (.sw_set(sw_set), .status_led(status_led), .switch_in(switch_in),
        .blinks(blinks));

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Prints the verdict and stops.
    task automatic end_of_test();
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Waits k edges, then lets their updates settle.
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : cyc

    // Next pseudo-random value.
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nxt

    // Expected decode: mode, source, adapter, truncated, nibble, sample port.
    function automatic logic [6:0] exp_cfg(input logic [7:0] v);
        logic [1:0] m;
        logic       t;
        m = {v[SW_MODE_A], v[SW_MODE_B]};
        t = (m != MODE_TEST) && v[SW_TRUNC];
        return {m, (m == MODE_LEGACY) && v[SW_LINSRC], t && v[SW_ADAPT], t,
                v[SW_NIB_M], v[SW_PCM_M]};
    endfunction : exp_cfg

    // One APB transfer; holds the request until pready is seen.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            fails++;
            end_of_test();
        end
    endtask : apb

    // Counts cycles until the run lamp changes, with a bound.
    task automatic wait_blink(output int k);
        int b;
        b = blinks;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (blinks == b && k < 400);
        if (k >= 400) begin
            fails++;
            end_of_test();
        end
    endtask : wait_blink

    // Power-up with a given switch image; held 12 cycles.
    task automatic do_reset(input logic [7:0] v);
        @(posedge pclk);
        presetn <= 1'b0;
        sw_set <= v;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cyc(5);
    endtask : do_reset

    // ****************************************************************
    // Main sequence
    // ****************************************************************

    initial begin
        // Every mode with all switches on, then random images.
        for (int i = 0; i < 12; i++) begin
            lfsr = nxt(lfsr);
            s = (i < 4) ? {i[1:0], 6'h1F} : lfsr[7:0];
            e = exp_cfg(s);
            do_reset(s);
            chk(32'(cfg), 32'(e));
            chk(32'(status_led[3:2]), 32'(e[2]));
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            chk(32'(rd[15:0]), {16'h0000, 1'b1, e[4], e[1], e[0], e[3], e[2], e[6:5],
                s & 8'hDF});
            @(posedge pclk);
            sw_set <= ~s;
            cyc(6);
            chk(32'(cfg), 32'(e));
        end
        // Indicator mapping through the register bus.
        apb(1'b0, ADDR_LEDSEL, 32'h0000_0000);
        chk(rd, {14'h0000, LEDSEL_RST});
        apb(1'b1, ADDR_LEDSEL, 32'h0003_FFFF);
        cyc(3);
        chk(32'(status_led), 32'h0000_003F);
        apb(1'b1, ADDR_LEDSEL, 32'h0003_6DB6);
        cyc(3);
        chk(32'(status_led), 32'h0000_0000);
        apb(1'b0, ADDR_LEDSEL, 32'h0000_0000);
        chk(rd, 32'h0003_6DB6);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b0, ADDR_PEAK, 32'h0000_0000);
        chk(rd, 32'(PEAK_THR_RST));
        apb(1'b0, ADDR_ACT, 32'h0000_0000);
        chk(rd, 32'(ACT_THR_RST));
        apb(1'b1, ADDR_LEDSEL, {14'h0000, LEDSEL_RST});
        // Level lamps just below and at each threshold.
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            audio_level <= lv[k];
            cyc(3);
            chk(32'(status_led[1:0]), 32'(le[k]));
        end
        // A one-cycle error, then a one-cycle slip, each stretched.
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            {sample_slip, error_event} <= 2'(k + 1);
            @(posedge pclk);
            {sample_slip, error_event} <= 2'b00;
            cyc(2);
            chk(32'(status_led[3]), 32'h0000_0001);
            cyc(STR - 3);
            chk(32'(status_led[3]), 32'h0000_0001);
            cyc(6);
            chk(32'(status_led[3]), 32'h0000_0000);
        end
        // Voice lamp over every encoder and decoder combination.
        for (int k = 0; k < 16; k++) begin
            @(posedge pclk);
            voc <= 4'(k);
            cyc(3);
            chk(32'(status_led[4]), 32'((k[3] & k[2]) | (k[1] & k[0])));
        end
        // Run lamp half period follows random loads.
        for (int k = 0; k < 3; k++) begin
            lfsr = nxt(lfsr);
            @(posedge pclk);
            cpu_load <= 8'(lfsr[2:0]);
            wait_blink(n);
            wait_blink(n);
            wait_blink(n);
            chk(32'(n), 32'(RB + lfsr[2:0] + 1));
        end
        end_of_test();
    end
endmodule : strap_config_and_status_leds_tb_top
